/* rtl/chunk_appender.sv */
// Purpose: Appends per-frame metadata items to each picture payload
// Assumes: Wishbone classic slave, stream sources on clk_i, one word/2 cycles
// Notes:   Items follow the picture as {id,len} header plus data words
// Contract
// [R1] Master switch on adds enabled items; off adds nothing after the picture
// [R2] Selector offers twelve items, picture through serial data
// [R3] Include flag reads and writes the item named by the selector
// [R4] Picture item include stays set; clearing it has no effect
// [R5] Picture and check code items always sent while append is on
// [R6] Configuration writes rejected while acquisition runs
// [R7] Host stops acquisition before changing items
// [R8] Frame counter item carries the id of its own frame
// [R9] Origin items give the region origin applied to the frame
// [R10] Size items give columns and rows actually captured
// [R11] Shutter item holds the duration used for the frame
// [R12] Amplification item holds the applied gain, chosen by a selector; here any selector value other than PICK_ALL gives zero
// [R13] Dark offset item holds applied black level, chosen by a selector; here any selector value other than PICK_ALL gives zero
// [R14] Layout item reports the delivered pixel format code
// [R15] Time item carries the time stamp latched for the frame
// [R16] Serial item appends received bytes with their count
// [R17] Serial item carries the receive overrun flag
// [R18] Items follow the picture in fixed order, each with id and length
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module chunk_appender (
  input  wire logic        clk_i,        // 20 MHz clock
  input  wire logic        rst_i,        // Synchronous reset, high
  input  wire logic        wb_cyc_i,     // Bus cycle
  input  wire logic        wb_stb_i,     // Bus strobe
  input  wire logic        wb_we_i,      // Write enable
  input  wire logic [7:0]  wb_adr_i,     // Byte address
  input  wire logic [3:0]  wb_sel_i,     // Byte lanes
  input  wire logic [31:0] wb_dat_i,     // Write data
  output logic      [31:0] wb_dat_o,     // Read data
  output logic             wb_ack_o,     // Acknowledge
  output logic             irq_o,        // Level interrupt
  input  wire logic        acq_run_i,    // Acquisition running
  input  wire logic        frame_start_i,// Pulse, metadata valid
  input  wire logic [31:0] frame_id_i,   // Frame counter value
  input  wire logic [15:0] origin_h_i,   // Applied horizontal origin
  input  wire logic [15:0] origin_v_i,   // Applied vertical origin
  input  wire logic [15:0] cols_i,       // Captured width
  input  wire logic [15:0] rows_i,       // Captured height
  input  wire logic [31:0] shutter_i,    // Exposure used
  input  wire logic [31:0] amp_i,        // Gain applied
  input  wire logic [31:0] dark_i,       // Black level applied
  input  wire logic [7:0]  layout_i,     // Pixel format code
  input  wire logic [63:0] time_i,       // Latched time stamp
  input  wire logic [7:0]  rx_byte_i,    // Serial byte
  input  wire logic        rx_valid_i,   // Serial byte strobe
  input  wire logic [31:0] pix_data_i,   // Picture word
  input  wire logic        pix_valid_i,  // Picture word valid
  input  wire logic        pix_last_i,   // Last picture word
  output logic             pix_ready_o,  // Picture word taken
  output logic      [31:0] out_data_o,   // Payload word
  output logic             out_valid_o,  // Payload valid
  output logic             out_last_o,   // Last payload word
  input  wire logic        out_ready_i   // Link accepts
);
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_IMAGE = 2'b01,
    S_EMIT  = 2'b10
  } state_e;

  state_e                       state_q, state_d;
  logic                         append_q;
  logic [3:0]                   pick_q;
  logic [chunk_pkg::NITEMS-1:0] incl_q;
  logic                         amp_pk_q, dark_pk_q;
  logic [chunk_pkg::IRQ_W-1:0]  irq_st_q, irq_st_d, irq_msk_q, irq_ev;
  logic                         ack_q;
  logic [31:0]                  rdat_q;
  logic                         wr_fire, rd_fire, cfg_wr;
  // Per-frame metadata snapshot
  logic [31:0] m_frame_q, m_shut_q, m_amp_q, m_dark_q;
  logic [15:0] m_oh_q, m_ov_q, m_cols_q, m_rows_q;
  logic [7:0]  m_lay_q;
  logic [63:0] m_time_q;
  // Serial capture and snapshot
  logic [7:0]                 ubuf_q [chunk_pkg::UART_DEPTH];
  logic [7:0]                 usnap_q[chunk_pkg::UART_DEPTH];
  logic [chunk_pkg::UART_CW-1:0] ucnt_q, scnt_q;
  logic                       uovf_q, sovf_q, snap;
  // Stream and emission
  logic [31:0] out_data_q, out_data_d, chk_q, pcount_q, word;
  logic        out_valid_q, out_valid_d, out_last_q, out_last_d, ready_q;
  logic        load, take, push, skip, item_end;
  logic [3:0]  seq_q, item, last_seq;
  logic [2:0]  w_q;
  logic [15:0] dlen;

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdat_q;
  assign pix_ready_o = ready_q;
  assign out_data_o  = out_data_q;
  assign out_valid_o = out_valid_q;
  assign out_last_o  = out_last_q;

  // Bus handshake: ack one cycle after request, write at the acked edge
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  assign rd_fire = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_q;
  assign cfg_wr  = wr_fire & ~acq_run_i; // R6
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else       ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) rdat_q <= 32'h0000_0000;
    else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
      rdat_q <= 32'h0000_0000;
      unique case (wb_adr_i)
        chunk_pkg::OFS_CTRL:    rdat_q[chunk_pkg::CTRL_APPEND_BIT] <= append_q;
        chunk_pkg::OFS_PICK:    rdat_q[3:0] <= pick_q;
        chunk_pkg::OFS_INCLUDE: rdat_q[0] <= incl_q[pick_q]; // R3
        chunk_pkg::OFS_STATUS: begin
          rdat_q[chunk_pkg::ST_RUN_BIT]  <= acq_run_i;
          rdat_q[chunk_pkg::ST_BUSY_BIT] <= (state_q != S_IDLE);
        end
        chunk_pkg::OFS_IRQ_ST:  rdat_q[chunk_pkg::IRQ_W-1:0] <= irq_st_q;
        chunk_pkg::OFS_IRQ_MSK: rdat_q[chunk_pkg::IRQ_W-1:0] <= irq_msk_q;
        chunk_pkg::OFS_AMP_PK:  rdat_q[0] <= amp_pk_q;
        chunk_pkg::OFS_DARK_PK: rdat_q[0] <= dark_pk_q;
        default:                rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Chunk configuration; frozen while acquisition runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      append_q  <= 1'b0;
      pick_q    <= chunk_pkg::IT_PICTURE;
      incl_q    <= chunk_pkg::INCLUDE_RST;
      amp_pk_q  <= chunk_pkg::PICK_ALL;
      dark_pk_q <= chunk_pkg::PICK_ALL;
    end else if (cfg_wr) begin // R6
      if (wb_adr_i == chunk_pkg::OFS_CTRL)
        append_q <= wb_dat_i[chunk_pkg::CTRL_APPEND_BIT]; // R1
      // Codes past the last item are ignored, selector keeps its value
      if (wb_adr_i == chunk_pkg::OFS_PICK && wb_dat_i[3:0] <= chunk_pkg::IT_LASTPK)
        pick_q <= wb_dat_i[3:0]; // R2
      if (wb_adr_i == chunk_pkg::OFS_INCLUDE && pick_q != chunk_pkg::IT_PICTURE)
        incl_q[pick_q] <= wb_dat_i[0]; // R3 R4
      if (wb_adr_i == chunk_pkg::OFS_AMP_PK)
        amp_pk_q <= wb_dat_i[0]; // R12
      if (wb_adr_i == chunk_pkg::OFS_DARK_PK)
        dark_pk_q <= wb_dat_i[0]; // R13
    end
  end

  // Mask register is not chunk configuration, so it stays writable
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_msk_q <= chunk_pkg::MASK_RST;
    else if (wr_fire && wb_adr_i == chunk_pkg::OFS_IRQ_MSK)
      irq_msk_q <= wb_dat_i[chunk_pkg::IRQ_W-1:0];
  end

  // Sticky events, read clears, a new event wins over the clear
  always_comb begin
    irq_st_d = irq_st_q;
    if (rd_fire && wb_adr_i == chunk_pkg::OFS_IRQ_ST)
      irq_st_d = '0;
    irq_st_d = irq_st_d | irq_ev;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      irq_o    <= |(irq_st_d & irq_msk_q);
    end
  end

  // Metadata latched at frame start so items describe this frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_frame_q <= 32'h0000_0000;
      m_oh_q    <= 16'h0000;
      m_ov_q    <= 16'h0000;
      m_cols_q  <= 16'h0000;
      m_rows_q  <= 16'h0000;
      m_shut_q  <= 32'h0000_0000;
      m_amp_q   <= 32'h0000_0000;
      m_dark_q  <= 32'h0000_0000;
      m_lay_q   <= 8'h00;
      m_time_q  <= 64'h0000_0000_0000_0000;
    end else if (state_q == S_IDLE && frame_start_i) begin
      m_frame_q <= frame_id_i; // R8
      m_oh_q    <= origin_h_i; // R9
      m_ov_q    <= origin_v_i; // R9
      m_cols_q  <= cols_i; // R10
      m_rows_q  <= rows_i; // R10
      m_shut_q  <= shutter_i; // R11
      m_amp_q   <= (amp_pk_q == chunk_pkg::PICK_ALL) ? amp_i : 32'h0000_0000; // R12
      m_dark_q  <= (dark_pk_q == chunk_pkg::PICK_ALL) ? dark_i : 32'h0000_0000; // R13
      m_lay_q   <= layout_i; // R14
      m_time_q  <= time_i; // R15
    end
  end

  // Serial capture; bytes past the depth are dropped and flag overrun
  assign snap = take & pix_last_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ucnt_q <= '0;
      uovf_q <= 1'b0;
      scnt_q <= '0;
      sovf_q <= 1'b0;
    end else if (snap) begin
      scnt_q <= ucnt_q; // R16
      sovf_q <= uovf_q; // R17
      ucnt_q <= rx_valid_i ? 5'd1 : 5'd0;
      uovf_q <= 1'b0;
    end else if (rx_valid_i) begin
      if (ucnt_q == 5'(chunk_pkg::UART_DEPTH)) uovf_q <= 1'b1; // R17
      else ucnt_q <= ucnt_q + 5'd1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (snap) usnap_q <= ubuf_q;
    if (rx_valid_i) begin
      if (snap) ubuf_q[0] <= rx_byte_i;
      else if (ucnt_q < 5'(chunk_pkg::UART_DEPTH)) ubuf_q[ucnt_q[3:0]] <= rx_byte_i;
    end
  end

  // Item at a sequence position: picture, check code, then items 1..11
  always_comb begin
    if (seq_q == 4'h0)      item = chunk_pkg::IT_PICTURE;
    else if (seq_q == 4'h1) item = chunk_pkg::IT_CHECK;
    else                    item = seq_q - 4'h1;
  end
  // Highest sequence position that will send, for the end mark
  always_comb begin
    last_seq = 4'h1;
    for (int i = 2; i <= int'(chunk_pkg::SEQ_LAST); i++)
      if (incl_q[i-1]) last_seq = 4'(i);
  end

  // Data words per item and the word at the current index
  always_comb begin
    dlen = 16'h0001;
    if (item == chunk_pkg::IT_TIME) dlen = 16'h0002;
    if (item == chunk_pkg::IT_UART) dlen = 16'h0002 + 16'((scnt_q + 5'd3) >> 2); // R16
    word = 32'h0000_0000;
    if (w_q == 3'd0) word = {4'h0, chunk_pkg::ID_BASE | 12'(item), dlen}; // R18
    else unique case (item)
      chunk_pkg::IT_PICTURE: word = pcount_q;
      chunk_pkg::IT_CHECK:   word = chk_q;
      chunk_pkg::IT_FRAME:   word = m_frame_q; // R8
      chunk_pkg::IT_ORG_H:   word = {16'h0000, m_oh_q}; // R9
      chunk_pkg::IT_ORG_V:   word = {16'h0000, m_ov_q}; // R9
      chunk_pkg::IT_COLS:    word = {16'h0000, m_cols_q}; // R10
      chunk_pkg::IT_ROWS:    word = {16'h0000, m_rows_q}; // R10
      chunk_pkg::IT_SHUTTER: word = m_shut_q; // R11
      chunk_pkg::IT_AMP:     word = m_amp_q; // R12
      chunk_pkg::IT_DARK:    word = m_dark_q; // R13
      chunk_pkg::IT_LAYOUT:  word = {24'h00_0000, m_lay_q}; // R14
      chunk_pkg::IT_TIME:    word = (w_q == 3'd1) ? m_time_q[31:0] : m_time_q[63:32]; // R15
      chunk_pkg::IT_UART: begin
        if (w_q == 3'd1)      word = {27'h000_0000, scnt_q}; // R16
        else if (w_q == 3'd2) word = {31'h0000_0000, sovf_q}; // R17
        else for (int b = 0; b < 4; b++)
          if (5'({w_q - 3'd3, 2'(b)}) < scnt_q)
            word[8*b +: 8] = usnap_q[{w_q[1:0] - 2'd3, 2'(b)}]; // R16
      end
      default: word = 32'h0000_0000;
    endcase
  end

  // Emission control; disabled items are skipped in one idle cycle
  assign load     = ~out_valid_q | out_ready_i;
  assign take     = ready_q & pix_valid_i;
  assign skip     = (state_q == S_EMIT) & (seq_q > 4'h1) & ~incl_q[item]; // R5
  assign push     = (state_q == S_EMIT) & load & ~skip;
  assign item_end = push & (16'(w_q) == dlen);
  always_comb begin
    state_d     = state_q;
    out_data_d  = out_data_q;
    out_last_d  = out_last_q;
    out_valid_d = out_valid_q & ~out_ready_i;
    irq_ev      = '0;
    irq_ev[chunk_pkg::IRQ_OVF_BIT] = rx_valid_i & ~snap &
                                    (ucnt_q == 5'(chunk_pkg::UART_DEPTH)) & ~uovf_q;
    irq_ev[chunk_pkg::IRQ_REJ_BIT] = wr_fire & acq_run_i; // R6
    unique case (state_q)
      S_IDLE: if (frame_start_i) state_d = S_IMAGE;
      S_IMAGE: if (take) begin
        out_data_d  = pix_data_i;
        out_valid_d = 1'b1;
        out_last_d  = pix_last_i & ~append_q; // R1
        if (pix_last_i) begin
          state_d = append_q ? S_EMIT : S_IDLE; // R1 R5
          irq_ev[chunk_pkg::IRQ_DONE_BIT] = ~append_q;
        end
      end
      S_EMIT: if (push) begin
        out_data_d  = word;
        out_valid_d = 1'b1;
        out_last_d  = item_end & (seq_q == last_seq); // R18
        if (item_end && seq_q == last_seq) begin
          state_d = S_IDLE;
          irq_ev[chunk_pkg::IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Stream registers; ready is only offered when the slot will be empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= S_IDLE;
      out_valid_q <= 1'b0;
      out_last_q  <= 1'b0;
      out_data_q  <= 32'h0000_0000;
      ready_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      out_valid_q <= out_valid_d;
      out_last_q  <= out_last_d;
      out_data_q  <= out_data_d;
      ready_q     <= (state_d == S_IMAGE) & ~out_valid_d;
    end
  end

  // Sequence walk through items in fixed order
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != S_EMIT) begin
      seq_q <= 4'h0;
      w_q   <= 3'd0;
    end else if (skip || item_end) begin
      seq_q <= seq_q + 4'h1; // R18
      w_q   <= 3'd0;
    end else if (push) begin
      w_q   <= w_q + 3'd1;
    end
  end

  // Word count and rotate-xor check code over the picture words
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_q == S_IDLE && frame_start_i)) begin
      pcount_q <= 32'h0000_0000;
      chk_q    <= 32'h0000_0000;
    end else if (take) begin
      pcount_q <= pcount_q + 32'h0000_0001;
      chk_q    <= {chk_q[30:0], chk_q[31]} ^ pix_data_i; // R5
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;  wb_cyc_i && wb_stb_i && !ack_q; endsequence
  sequence s_cfgw; wr_fire && acq_run_i && wb_adr_i == chunk_pkg::OFS_CTRL; endsequence
  bus_ack_a: assert property (s_req |=> wb_ack_o) else $error("ack late");
  picture_keep_a: assert property (incl_q[0] && incl_q[12]) else $error("picture dropped"); // R4
  frozen_cfg_a: assert property (s_cfgw |=> $stable(append_q)) // R6
    else $error("write took effect while running");
  no_append_a: assert property (take && pix_last_i && !append_q |=> // R1
    out_last_q && state_q == S_IDLE) else $error("items after picture");
  emit_start_a: assert property (take && pix_last_i && append_q |=> // R5
    state_q == S_EMIT && !out_last_q) else $error("check item missing");
  hold_out_a: assert property (out_valid_q && !out_ready_i |=>
    out_valid_q && $stable(out_data_q)) else $error("word lost");
  frame_id_a: assert property (state_q == S_IDLE && frame_start_i |=> // R8
    m_frame_q == $past(frame_id_i)) else $error("frame id wrong");
  uart_cnt_a: assert property (ucnt_q <= 5'(chunk_pkg::UART_DEPTH)) // R16
    else $error("serial count overflow");
  header_len_a: assert property (push && w_q == 3'd0 |=> // R18
    out_data_q[15:0] == $past(dlen)) else $error("bad item header");
  irq_level_a: assert property (irq_o == |($past(irq_st_d) & $past(irq_msk_q)))
    else $error("irq level wrong");
endmodule : chunk_appender
`default_nettype wire

/* rtl/chunk_pkg.sv */
// Purpose: Shared constants for the image metadata appender
// Assumes: 32-bit Wishbone data, one clock at 20 MHz
// Notes:   Item codes double as stream identifiers; codes up to IT_LASTPK also as selector values
package chunk_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PICK    = 8'h04;
  localparam logic [7:0] OFS_INCLUDE = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
  localparam logic [7:0] OFS_AMP_PK  = 8'h18;
  localparam logic [7:0] OFS_DARK_PK = 8'h1C;
  // Field positions and widths
  localparam int CTRL_APPEND_BIT = 0;
  localparam int ST_RUN_BIT      = 0;
  localparam int ST_BUSY_BIT     = 1;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_OVF_BIT     = 1;
  localparam int IRQ_REJ_BIT     = 2;
  localparam int IRQ_W           = 3;
  localparam int NITEMS          = 13;
  // Reset values
  localparam logic [NITEMS-1:0] INCLUDE_RST = 13'h1001;
  localparam logic [IRQ_W-1:0]  MASK_RST    = 3'h0;
  // Item codes
  localparam logic [3:0] IT_PICTURE = 4'h0;
  localparam logic [3:0] IT_FRAME   = 4'h1;
  localparam logic [3:0] IT_ORG_H   = 4'h2;
  localparam logic [3:0] IT_ORG_V   = 4'h3;
  localparam logic [3:0] IT_COLS    = 4'h4;
  localparam logic [3:0] IT_ROWS    = 4'h5;
  localparam logic [3:0] IT_SHUTTER = 4'h6;
  localparam logic [3:0] IT_AMP     = 4'h7;
  localparam logic [3:0] IT_DARK    = 4'h8;
  localparam logic [3:0] IT_LAYOUT  = 4'h9;
  localparam logic [3:0] IT_TIME    = 4'hA;
  localparam logic [3:0] IT_UART    = 4'hB;
  localparam logic [3:0] IT_CHECK   = 4'hC;
  localparam logic [3:0] IT_LASTPK  = 4'hB;
  localparam logic [11:0] ID_BASE   = 12'h000;
  // Selector value for the single amplification and dark offset choice
  localparam logic PICK_ALL = 1'b0;
  // Serial capture depth in bytes
  localparam int UART_DEPTH = 16;
  localparam int UART_CW    = 5;
  // Sequence positions: picture, check code, then items 1..11
  localparam logic [3:0] SEQ_LAST = 4'hC;
endpackage : chunk_pkg

/* bench/link_sink.sv */
// Purpose: Host side of the payload link, collects words
// Assumes: Same clock as the appender, ready driven after edges
// Notes:   Stalls one cycle in three so held words get exercised
`timescale 1ns/1ps
`default_nettype none
module link_sink (
  input  wire logic        clk_i,    // Link clock
  input  wire logic        rst_i,    // Sync reset
  input  wire logic [31:0] data_i,   // Payload word
  input  wire logic        valid_i,  // Word valid
  input  wire logic        last_i,   // Last word
  output logic             ready_o   // Accept
);
  logic [31:0] dq[$];
  logic        lq[$];
  logic [1:0]  ph_q;
  // Stall pattern and capture of taken words
  always @(posedge clk_i) begin
    if (rst_i) begin
      ph_q    <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      ph_q    <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      ready_o <= (ph_q != 2'h1);
      if (valid_i === 1'b1 && ready_o) begin
        dq.push_back(data_i);
        lq.push_back(last_i);
      end
    end
  end
endmodule : link_sink
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the metadata appender
// Assumes: Wishbone classic master, one frame at a time
// Notes:   Expected payloads rebuilt here from item order and layout
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, acq = 0, fst = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, out_d;
  logic ack, irq, prdy, ovld, olast, ordy, pval = 0, plast = 0, rxv = 0;
  logic [31:0] pdat = 32'h0000_0000;
  // Per-frame metadata sources, moved by each frame after its start pulse
  logic [31:0] fid = 32'h0000_0005, sht = 32'h0000_1388, amp = 32'h0000_0C00;
  logic [15:0] oh = 16'h0010, ov = 16'h0020, cw = 16'h0280, rh = 16'h01E0;
  logic [7:0]  rxb = 8'h00;
  int mismatches = 0, num_checks = 0;
  logic [31:0] e[$];
  always #25 clk = ~clk;
  chunk_appender uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .acq_run_i(acq), .frame_start_i(fst),
    .frame_id_i(fid), .origin_h_i(oh), .origin_v_i(ov),
    .cols_i(cw), .rows_i(rh), .shutter_i(sht),
    .amp_i(amp), .dark_i(32'h0000_0040), .layout_i(8'h11),
    .time_i(64'h1234_5678_9ABC_DEF0), .rx_byte_i(rxb), .rx_valid_i(rxv),
    .pix_data_i(pdat), .pix_valid_i(pval), .pix_last_i(plast), .pix_ready_o(prdy),
    .out_data_o(out_d), .out_valid_o(ovld), .out_last_o(olast), .out_ready_i(ordy));
  link_sink sink (.clk_i(clk), .rst_i(rst), .data_i(out_d), .valid_i(ovld),
    .last_i(olast), .ready_o(ordy));
  task final_report;
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack is seen at an edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) mismatches++;
    r = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask : rd_chk
  function automatic logic [31:0] hdr(input logic [3:0] c, input logic [15:0] l);
    return {12'h000, c, l};
  endfunction : hdr
  // Frame of n picture words, then compare the whole payload with e
  task frame(input int n);
    int k;
    sink.dq.delete();
    sink.lq.delete();
    @(posedge clk) fst <= 1;
    @(posedge clk) fst <= 0;
    // Sources move after the start pulse; items must keep the latched values
    fid <= ~fid;
    sht <= ~sht;
    {oh, ov, cw, rh, amp} <= ~{oh, ov, cw, rh, amp};
    for (int i = 0; i < n; i++) begin
      pval <= 1; pdat <= 32'hA5A5_0000 + i; plast <= (i == n - 1);
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (prdy !== 1'b1 && k < 50);
      if (prdy !== 1'b1) mismatches++;
    end
    pval <= 0; plast <= 0;
    k = 0;
    while (sink.dq.size() < e.size() && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    chk(sink.dq.size(), e.size());
    for (int i = 0; i < e.size() && i < sink.dq.size(); i++) begin
      chk(sink.dq[i], e[i]);
      chk(sink.lq[i], i == e.size() - 1);
    end
  endtask : frame
  task t_reset;
    rd_chk(chunk_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk(chunk_pkg::OFS_INCLUDE, 32'h0000_0001);
    rd_chk(8'h20, 32'h0000_0000);
  endtask : t_reset
  task t_off;
    e = {32'hA5A5_0000, 32'hA5A5_0001};
    frame(2);
  endtask : t_off
  // Every selectable item, independence and the fixed picture flag
  task t_config;
    wr(chunk_pkg::OFS_CTRL, 32'h0000_0001);
    for (int i = 1; i <= 11; i++) begin
      wr(chunk_pkg::OFS_PICK, i);
      wr(chunk_pkg::OFS_INCLUDE, 32'h0000_0001);
      rd_chk(chunk_pkg::OFS_INCLUDE, 32'h0000_0001);
    end
    wr(chunk_pkg::OFS_PICK, 5);
    wr(chunk_pkg::OFS_INCLUDE, 32'h0000_0000);
    rd_chk(chunk_pkg::OFS_INCLUDE, 32'h0000_0000);
    wr(chunk_pkg::OFS_PICK, 4);
    rd_chk(chunk_pkg::OFS_INCLUDE, 32'h0000_0001);
    wr(chunk_pkg::OFS_PICK, 5);
    wr(chunk_pkg::OFS_INCLUDE, 32'h0000_0001);
    wr(chunk_pkg::OFS_PICK, 0);
    wr(chunk_pkg::OFS_INCLUDE, 32'h0000_0000);
    rd_chk(chunk_pkg::OFS_INCLUDE, 32'h0000_0001);
    wr(chunk_pkg::OFS_PICK, 32'h0000_000C);
    rd_chk(chunk_pkg::OFS_PICK, 32'h0000_0000);
  endtask : t_config
  // Full payload while running, with a refused write and its interrupt
  task t_full;
    logic [31:0] c;
    c = {31'h0, 1'b0} ^ 32'hA5A5_0000;
    c = {c[30:0], c[31]} ^ 32'hA5A5_0001;
    e = {32'hA5A5_0000, 32'hA5A5_0001, hdr(4'h0, 1), 2, hdr(4'hC, 1), c,
         hdr(4'h1, 1), 5, hdr(4'h2, 1), 32'h10, hdr(4'h3, 1), 32'h20,
         hdr(4'h4, 1), 32'h280, hdr(4'h5, 1), 32'h1E0, hdr(4'h6, 1), 32'h1388,
         hdr(4'h7, 1), 32'hC00, hdr(4'h8, 1), 32'h40, hdr(4'h9, 1), 32'h11,
         hdr(4'hA, 2), 32'h9ABC_DEF0, 32'h1234_5678, hdr(4'hB, 3), 3, 0,
         32'h0033_2211};
    @(posedge clk) begin
      acq <= 1;
      fid <= 32'h0000_0005;
      sht <= 32'h0000_1388;
      {oh, ov, cw, rh, amp} <= {16'h0010, 16'h0020, 16'h0280, 16'h01E0, 32'h0000_0C00};
    end
    wr(chunk_pkg::OFS_IRQ_MSK, 32'h0000_0004);
    wr(chunk_pkg::OFS_CTRL, 32'h0000_0000);
    for (int i = 1; i <= 3; i++) begin
      @(posedge clk) begin rxv <= 1; rxb <= 8'h11 * i; end
      @(posedge clk) rxv <= 0;
    end
    frame(2);
    rd_chk(chunk_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(chunk_pkg::OFS_STATUS, 32'h0000_0001);
    chk(irq, 1'b1);
    rd_chk(chunk_pkg::OFS_IRQ_ST, 32'h0000_0005);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    @(posedge clk) acq <= 0;
  endtask : t_full
  // Serial overrun, only dark offset and serial items, dark picker at 1
  task t_serial;
    for (int i = 1; i <= 10; i++) begin
      wr(chunk_pkg::OFS_PICK, i);
      wr(chunk_pkg::OFS_INCLUDE, {31'h0000_0000, i == 8});
    end
    wr(chunk_pkg::OFS_DARK_PK, 32'h0000_0001);
    for (int i = 1; i <= 17; i++) begin
      @(posedge clk) begin
        rxv <= 1;
        rxb <= 8'(i);
      end
      @(posedge clk) rxv <= 0;
    end
    e = {32'hA5A5_0000, hdr(4'h0, 1), 1, hdr(4'hC, 1), 32'hA5A5_0000,
         hdr(4'h8, 1), 0, hdr(4'hB, 6), 16, 1, 32'h0403_0201, 32'h0807_0605,
         32'h0C0B_0A09, 32'h100F_0E0D};
    frame(1);
    rd_chk(chunk_pkg::OFS_IRQ_ST, 32'h0000_0003);
  endtask : t_serial
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_reset();
    t_off();
    t_config();
    t_full();
    t_serial();
    final_report();
  end
  // Watchdog far beyond the expected run length
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
